// ==== hdl/lcf_config_page.v ====
// Purpose: Configuration register page of a load cell measurement channel
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 100 MHz clock
// Notes:   Every access is answered with exactly one cycle of waitrequest
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
`include "lcf_consts.vh"

module lcf_config_page #(
  parameter WDOG_CYCLES = `LCF_WDOG_TIME_MS * `LCF_CLK_FREQ_KHZ
) (
  input  wire        clock,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg         irq,
  // Measurement side, same clock domain
  input  wire [15:0] meas_value,
  input  wire        meas_valid,
  input  wire        recal_done,
  input  wire        weight_stable,
  input  wire        process_data_seen,
  output reg  [15:0] out_value,
  output reg         out_valid,
  output reg         watchdog_trip,
  // Configuration controls
  output reg         hold_until_settled,
  output reg         sensitivity_unit_select,
  output reg         user_correction_select,
  output reg         calibration_stabilize_on,
  output reg         scale_factor_on,
  output reg         symmetric_measure_on,
  output reg         reference_cycle_off,
  output reg         self_test_cycle_off,
  output reg         converter_calibration_off,
  output reg         watchdog_off,
  output reg         factory_scaling_on,
  output reg         user_correction_on,
  output reg  [15:0] rated_weight_kg,
  output reg  [22:0] rated_sens_centi
);

  // Register storage
  reg [15:0]                feature_config_word_reg;
  reg [15:0]                user_offset_word_reg;
  reg [15:0]                user_gain_word_reg;
  reg [15:0]                cell_rated_weight_reg;
  reg [15:0]                cell_rated_sensitivity_reg;
  reg [15:0]                unlock_key_register_reg;
  reg [15:0]                page_select_register_reg;
  reg [`LCF_IRQ_WIDTH-1:0]  irq_status_reg;
  reg [`LCF_IRQ_WIDTH-1:0]  irq_mask_reg;
  reg [`LCF_IRQ_WIDTH-1:0]  irq_status_next;
  reg [31:0]                wdog_count_reg;
  reg                       settle_wait_reg;
  reg                       reject_pulse;
  reg                       settled_pulse;
  reg [31:0]                read_mux;

  // Decode
  wire [5:0]  reg_index   = address[7:2];
  wire        lane_ok     = (address[1:0] == 2'b00);
  wire        wr_go       = write & ~waitrequest & lane_ok;
  wire        rd_go       = read & ~waitrequest & lane_ok;
  wire        page_cfg    = (page_select_register_reg == `LCF_PAGE_CONFIG);
  wire        unlocked    = (unlock_key_register_reg == `LCF_USER_KEY);
  wire        user_index  = (reg_index >= `LCF_IDX_FEATURE) &&
                            (reg_index <= `LCF_IDX_RATED_SENS);
  wire        user_wr     = wr_go & user_index & page_cfg;
  wire        user_wr_ok  = user_wr & unlocked;
  wire [15:0] wdata16     = {byteenable[1] ? writedata[15:8] : 8'h00,
                             byteenable[0] ? writedata[7:0]  : 8'h00};
  wire [15:0] wbe_mask    = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // Byte lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] be_mask;
    begin
      merge16 = (old_val & ~be_mask) | (new_val & be_mask);
    end
  endfunction

  // Bus handshake: one wait cycle, then the access completes
  // Registered so the answer never depends combinationally on the strobes
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      waitrequest <= 1'b1;
    else if ((read | write) & waitrequest)
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // Read mux; user registers on other pages and unmapped indices read zero
  always @*
  begin
    read_mux = 32'h0000_0000;
    case (reg_index)
      `LCF_IDX_PAGE_SELECT:  read_mux = {16'h0000, page_select_register_reg};
      `LCF_IDX_IRQ_STATUS:   read_mux = {29'h0000_0000, irq_status_reg};
      `LCF_IDX_IRQ_MASK:     read_mux = {29'h0000_0000, irq_mask_reg};
      `LCF_IDX_UNLOCK_KEY:   read_mux = {16'h0000, unlock_key_register_reg};
      `LCF_IDX_FEATURE:
        if (page_cfg)
          read_mux = {16'h0000, feature_config_word_reg};
      `LCF_IDX_USER_OFFSET:
        if (page_cfg)
          read_mux = {16'h0000, user_offset_word_reg};
      `LCF_IDX_USER_GAIN:
        if (page_cfg)
          read_mux = {16'h0000, user_gain_word_reg};
      `LCF_IDX_RATED_WEIGHT:
        if (page_cfg)
          read_mux = {16'h0000, cell_rated_weight_reg};
      `LCF_IDX_RATED_SENS:
        if (page_cfg)
          read_mux = {16'h0000, cell_rated_sensitivity_reg};
      default:               read_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured as waitrequest falls and stands one cycle past it
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      readdata <= 32'h0000_0000;
    else if (read & waitrequest)
      readdata <= lane_ok ? read_mux : 32'h0000_0000;
  end

  // Key and page select; the key survives only until the next reset
  // Never refused by the lock, or a locked host could not unlock
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      unlock_key_register_reg  <= `LCF_RST_KEY;
      page_select_register_reg <= `LCF_RST_PAGE;
    end
    else if (wr_go)
    begin
      if (reg_index == `LCF_IDX_UNLOCK_KEY)
        unlock_key_register_reg <= merge16(unlock_key_register_reg, wdata16, wbe_mask);
      // Pages beyond the last one leave the old page in place
      if (reg_index == `LCF_IDX_PAGE_SELECT &&
          merge16(page_select_register_reg, wdata16, wbe_mask) <= `LCF_PAGE_LAST)
        page_select_register_reg <= merge16(page_select_register_reg, wdata16, wbe_mask);
    end
  end

  // User registers: written only when unlocked and page 0 is selected
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      feature_config_word_reg    <= `LCF_RST_FEATURE;
      user_offset_word_reg       <= `LCF_RST_USER_OFFSET;
      user_gain_word_reg         <= `LCF_RST_USER_GAIN;
      cell_rated_weight_reg      <= `LCF_RST_RATED_WEIGHT;
      cell_rated_sensitivity_reg <= `LCF_RST_RATED_SENS;
    end
    else if (user_wr_ok)
    begin
      case (reg_index)
        `LCF_IDX_FEATURE:
          feature_config_word_reg <= merge16(feature_config_word_reg, wdata16,
                                             wbe_mask) & `LCF_FEATURE_WMASK;
        `LCF_IDX_USER_OFFSET:
          user_offset_word_reg <= merge16(user_offset_word_reg, wdata16, wbe_mask);
        `LCF_IDX_USER_GAIN:
          user_gain_word_reg <= merge16(user_gain_word_reg, wdata16, wbe_mask);
        `LCF_IDX_RATED_WEIGHT:
          cell_rated_weight_reg <= merge16(cell_rated_weight_reg, wdata16, wbe_mask);
        `LCF_IDX_RATED_SENS:
          cell_rated_sensitivity_reg <= merge16(cell_rated_sensitivity_reg, wdata16,
                                                wbe_mask);
        default:
          feature_config_word_reg <= feature_config_word_reg;
      endcase
    end
  end

  // Feature bits and rated values exported as registered controls
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      hold_until_settled        <= 1'b0;
      sensitivity_unit_select   <= 1'b0;
      user_correction_select    <= 1'b0;
      calibration_stabilize_on  <= 1'b0;
      scale_factor_on           <= 1'b0;
      symmetric_measure_on      <= 1'b0;
      reference_cycle_off       <= 1'b0;
      self_test_cycle_off       <= 1'b0;
      converter_calibration_off <= 1'b0;
      watchdog_off              <= 1'b0;
      factory_scaling_on        <= 1'b0;
      user_correction_on        <= 1'b0;
      rated_weight_kg           <= 16'h0000;
      rated_sens_centi          <= 23'h00_0000;
    end
    else
    begin
      hold_until_settled        <= feature_config_word_reg[`LCF_B_HOLD_SETTLED];
      sensitivity_unit_select   <= feature_config_word_reg[`LCF_B_SENS_UNIT];
      user_correction_select    <= feature_config_word_reg[`LCF_B_CORR_SELECT];
      calibration_stabilize_on  <= feature_config_word_reg[`LCF_B_CAL_STABILIZE];
      scale_factor_on           <= feature_config_word_reg[`LCF_B_SCALE_FACTOR];
      symmetric_measure_on      <= feature_config_word_reg[`LCF_B_SYMMETRIC];
      reference_cycle_off       <= feature_config_word_reg[`LCF_B_REF_OFF];
      self_test_cycle_off       <= feature_config_word_reg[`LCF_B_TEST_OFF];
      converter_calibration_off <= feature_config_word_reg[`LCF_B_CONV_CAL_OFF];
      watchdog_off              <= feature_config_word_reg[`LCF_B_WATCHDOG_OFF];
      factory_scaling_on        <= feature_config_word_reg[`LCF_B_FACTORY_SCALE];
      user_correction_on        <= feature_config_word_reg[`LCF_B_USER_CORR_ON];
      rated_weight_kg           <= cell_rated_weight_reg;
      // Normalise sensitivity to hundredths of mV/V
      if (feature_config_word_reg[`LCF_B_SENS_UNIT])
        rated_sens_centi <= {7'h00, cell_rated_sensitivity_reg};
      else
        rated_sens_centi <= {7'h00, cell_rated_sensitivity_reg} *
                            {16'h0000, `LCF_CENTI_PER_UNIT};
    end
  end

  // User correction: value * gain / 2048 + offset, truncated to 16 bits.
  // Both select values share this form; the calibration commands that
  // derive the words live elsewhere.
  wire signed [16:0] gain_s   = {1'b0, user_gain_word_reg};
  wire signed [32:0] prod     = $signed(meas_value) * gain_s;
  wire signed [32:0] scaled   = prod >>> `LCF_GAIN_FRAC_BITS;
  wire signed [32:0] offs_ext = {{17{user_offset_word_reg[15]}}, user_offset_word_reg};
  wire signed [32:0] corr_sum = scaled + offs_ext;
  wire               corr_en  = feature_config_word_reg[`LCF_B_USER_CORR_ON];
  // Select bit is exported only; this datapath does not depend on it
  wire [15:0]        corr_val = corr_en ? corr_sum[15:0] : meas_value;

  // Settling hold: a recalibration arms the wait, stability releases it
  // Clearing the hold bit mid-wait releases the output one clock later
  wire hold_on      = feature_config_word_reg[`LCF_B_HOLD_SETTLED];
  wire settle_block = settle_wait_reg & ~weight_stable;
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      settle_wait_reg <= 1'b0;
      settled_pulse   <= 1'b0;
    end
    else
    begin
      settled_pulse <= settle_wait_reg & weight_stable & ~recal_done;
      if (recal_done & hold_on)
        settle_wait_reg <= 1'b1;
      else if (weight_stable | ~hold_on)
        settle_wait_reg <= 1'b0;
    end
  end

  // Output value; held back while the settle wait is active and the weight is not stable
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      out_value <= 16'h0000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= meas_valid & ~settle_block;
      if (meas_valid & ~settle_block)
        out_value <= corr_val;
    end
  end

  // Watchdog: restarts on process data; disabled means held at zero.
  // Wide counter so a long default fits; shorten via WDOG_CYCLES in sim.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wdog_count_reg <= 32'h0000_0000;
      watchdog_trip  <= 1'b0;
    end
    else if (feature_config_word_reg[`LCF_B_WATCHDOG_OFF] | process_data_seen)
    begin
      wdog_count_reg <= 32'h0000_0000;
      watchdog_trip  <= 1'b0;
    end
    else if (wdog_count_reg == WDOG_CYCLES - 1)
    begin
      wdog_count_reg <= 32'h0000_0000;
      watchdog_trip  <= 1'b1;
    end
    else
    begin
      wdog_count_reg <= wdog_count_reg + 32'h0000_0001;
      watchdog_trip  <= 1'b0;
    end
  end

  // Locked writes flag a rejection event
  // Writes on pages 1 and 2 are not user writes, so never flagged
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      reject_pulse <= 1'b0;
    else
      reject_pulse <= user_wr & ~unlocked;
  end

  // Sticky status, cleared by reading it; a new event beats the clear.
  // Only the bits the read returned are cleared, so an event that lands
  // while the read waits is kept for the next read.
  always @*
  begin
    irq_status_next = irq_status_reg;
    if (rd_go && reg_index == `LCF_IDX_IRQ_STATUS)
      irq_status_next = irq_status_reg & ~readdata[`LCF_IRQ_WIDTH-1:0];
    irq_status_next[`LCF_I_WATCHDOG]     = irq_status_next[`LCF_I_WATCHDOG] | watchdog_trip;
    irq_status_next[`LCF_I_WRITE_REJECT] = irq_status_next[`LCF_I_WRITE_REJECT] |
                                           reject_pulse;
    irq_status_next[`LCF_I_SETTLED]      = irq_status_next[`LCF_I_SETTLED] | settled_pulse;
  end

  // Status, mask and level interrupt
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      irq_status_reg <= {`LCF_IRQ_WIDTH{1'b0}};
      irq_mask_reg   <= {`LCF_IRQ_WIDTH{1'b0}};
      irq            <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (wr_go && reg_index == `LCF_IDX_IRQ_MASK && byteenable[0])
        irq_mask_reg <= writedata[`LCF_IRQ_WIDTH-1:0];
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule // lcf_config_page

// ==== hdl/lcf_consts.vh ====
// Purpose: Constants for the load cell feature configuration page
// Assumes: Byte address on the bus is four times the register index
// Notes:   Definitions only
`ifndef LCF_CONSTS_VH
`define LCF_CONSTS_VH

// Register indices (byte address = index * 4)
`define LCF_IDX_PAGE_SELECT   6'h04
`define LCF_IDX_IRQ_STATUS    6'h08
`define LCF_IDX_IRQ_MASK      6'h09
`define LCF_IDX_UNLOCK_KEY    6'h1F
`define LCF_IDX_FEATURE       6'h20
`define LCF_IDX_USER_OFFSET   6'h21
`define LCF_IDX_USER_GAIN     6'h22
`define LCF_IDX_RATED_WEIGHT  6'h23
`define LCF_IDX_RATED_SENS    6'h24

// Reset values
`define LCF_RST_FEATURE       16'h0380
`define LCF_RST_USER_OFFSET   16'h0000
`define LCF_RST_USER_GAIN     16'h0800
`define LCF_RST_RATED_WEIGHT  16'h0005
`define LCF_RST_RATED_SENS    16'h0002
`define LCF_RST_PAGE          16'h0000
`define LCF_RST_KEY           16'h0000

// Unlock key and page limits
`define LCF_USER_KEY          16'h1235
`define LCF_PAGE_CONFIG       16'h0000
`define LCF_PAGE_LAST         16'h0002

// Writable bits of the feature word (bits 15, 13, 3 reserved)
`define LCF_FEATURE_WMASK     16'h5FF7

// Feature word bit positions
`define LCF_B_HOLD_SETTLED    12
`define LCF_B_SENS_UNIT       11
`define LCF_B_CORR_SELECT     10
`define LCF_B_CAL_STABILIZE   9
`define LCF_B_SCALE_FACTOR    8
`define LCF_B_SYMMETRIC       7
`define LCF_B_REF_OFF         6
`define LCF_B_TEST_OFF        5
`define LCF_B_CONV_CAL_OFF    4
`define LCF_B_WATCHDOG_OFF    2
`define LCF_B_FACTORY_SCALE   1
`define LCF_B_USER_CORR_ON    0

// Interrupt status bits
`define LCF_IRQ_WIDTH         3
`define LCF_I_WATCHDOG        0
`define LCF_I_WRITE_REJECT    1
`define LCF_I_SETTLED         2

// Gain fraction: word / 2048 is the factor
`define LCF_GAIN_FRAC_BITS    11
// Centi units per mV/V
`define LCF_CENTI_PER_UNIT    7'h64

// Timing
`define LCF_CLK_FREQ_KHZ      100000
`define LCF_WDOG_TIME_MS      100

`endif

// ==== testbench/lcf_config_page_chk.sv ====
// Purpose: Port-level assertions for the load cell configuration page
// Assumes: Single clock domain, reset asynchronous and active high
// Notes:   Bound to every instance of the design by the bind below
`timescale 1ns/1ns
module lcf_config_page_chk #(
  parameter WDOG_CYCLES = 20
) (
  input wire        clock,
  input wire        reset,
  input wire        read,
  input wire        write,
  input wire        waitrequest,
  input wire        irq,
  input wire [15:0] meas_value,
  input wire        meas_valid,
  input wire        weight_stable,
  input wire        process_data_seen,
  input wire [15:0] out_value,
  input wire        out_valid,
  input wire        watchdog_trip,
  input wire        watchdog_off,
  input wire        user_correction_on,
  input wire        calibration_stabilize_on,
  input wire        scale_factor_on,
  input wire        symmetric_measure_on,
  input wire [15:0] rated_weight_kg,
  input wire [22:0] rated_sens_centi
);
  reg [31:0] quiet_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Cycles since the last sign of life or trip; never cleared by the
  // disable bit, so a design that restarts its count only trips later
  always @(posedge clock or posedge reset)
    if (reset)
      quiet_reg <= 32'h0000_0000;
    else if (process_data_seen || watchdog_trip)
      quiet_reg <= 32'h0000_0000;
    else
      quiet_reg <= quiet_reg + 32'h0000_0001;

  chk_wait_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  chk_irq_clear: assert property ($fell(irq) |-> $past(!waitrequest) || $past(!waitrequest, 2))
    else $error("irq fell without a bus access");
  chk_meas_taken: assert property (meas_valid && weight_stable |=> out_valid)
    else $error("sample with stable weight not passed on");
  chk_meas_cause: assert property (out_valid |-> $past(meas_valid))
    else $error("out_valid without a sample");
  chk_corr_off: assert property (meas_valid && weight_stable && !user_correction_on
    ##1 !user_correction_on |-> out_value == $past(meas_value))
    else $error("value altered with correction off");
  chk_wdog_quiet: assert property (watchdog_off && $past(watchdog_off) |-> !watchdog_trip)
    else $error("watchdog tripped while disabled");
  chk_wdog_period: assert property (watchdog_trip |-> quiet_reg >= WDOG_CYCLES - 1)
    else $error("watchdog tripped too early");
  chk_reset_ctrl: assert property ($fell(reset) |=> calibration_stabilize_on && scale_factor_on
    && symmetric_measure_on && rated_weight_kg == 16'h0005
    && rated_sens_centi == 23'h00_00C8)
    else $error("control outputs wrong after reset");
endmodule // lcf_config_page_chk

bind lcf_config_page lcf_config_page_chk #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (
  .clock(clock), .reset(reset), .read(read), .write(write), .waitrequest(waitrequest),
  .irq(irq), .meas_value(meas_value), .meas_valid(meas_valid),
  .weight_stable(weight_stable), .process_data_seen(process_data_seen),
  .out_value(out_value), .out_valid(out_valid), .watchdog_trip(watchdog_trip),
  .watchdog_off(watchdog_off), .user_correction_on(user_correction_on),
  .calibration_stabilize_on(calibration_stabilize_on), .scale_factor_on(scale_factor_on),
  .symmetric_measure_on(symmetric_measure_on), .rated_weight_kg(rated_weight_kg),
  .rated_sens_centi(rated_sens_centi)
);

// ==== testbench/lcf_host_model.sv ====
// Purpose: Host software model speaking Avalon-MM to the config page
// Assumes: Slave answers by dropping waitrequest; no cycle count assumed
// Notes:   Released write data shows the inverse so stale data is not seen
`timescale 1ns/1ns
module lcf_host_model (
  input  wire        clock,
  input  wire        waitrequest,
  input  wire [31:0] readdata,
  output reg  [7:0]  address,
  output reg         read,
  output reg         write,
  output reg  [31:0] writedata,
  output reg  [3:0]  byteenable
);
  // Idle bus at time zero
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
  end

  // Caller unlocks with the key and selects page 0 first
  task bus_write;
    input [7:0]  a;
    input [15:0] d;
    begin
      @(posedge clock);
      address <= a;
      writedata <= {16'h0000, d};
      write <= 1'b1;
      @(posedge clock);
      while (waitrequest)
        @(posedge clock);
      write <= 1'b0;
      writedata <= ~writedata;
    end
  endtask

  // Data is taken at the same edge that sees waitrequest low
  task bus_read;
    input  [7:0]  a;
    output [31:0] d;
    begin
      @(posedge clock);
      address <= a;
      read <= 1'b1;
      @(posedge clock);
      while (waitrequest)
        @(posedge clock);
      d = readdata;
      read <= 1'b0;
    end
  endtask
endmodule // lcf_host_model

// ==== testbench/lcf_config_page_test.sv ====
// Purpose: Self-checking test of the load cell configuration page
// Assumes: Watchdog count shortened to 20 cycles
// Notes:   Process data is fed every other cycle unless feeding stops
`timescale 1ns/1ns
`include "lcf_consts.vh"
module lcf_config_page_test;
  reg         clock;
  reg         reset;
  reg         feed;
  reg  [15:0] meas_value;
  reg         meas_valid;
  reg         recal_done;
  reg         weight_stable;
  reg         process_data_seen;
  wire [7:0]  address;
  wire        read;
  wire        write;
  wire [31:0] writedata;
  wire [3:0]  byteenable;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        irq;
  wire [15:0] out_value;
  wire        out_valid;
  wire        watchdog_trip;
  wire [11:0] ctl;
  wire [15:0] weight_kg;
  wire [22:0] sens_centi;
  integer     n_errors;
  integer     num_checks;
  integer     k;
  reg  [31:0] v;

  lcf_host_model u_host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));

  lcf_config_page #(.WDOG_CYCLES(20)) dut (.clock(clock), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .meas_value(meas_value), .meas_valid(meas_valid), .recal_done(recal_done),
    .weight_stable(weight_stable), .process_data_seen(process_data_seen),
    .out_value(out_value), .out_valid(out_valid), .watchdog_trip(watchdog_trip),
    .hold_until_settled(ctl[11]), .sensitivity_unit_select(ctl[10]),
    .user_correction_select(ctl[9]), .calibration_stabilize_on(ctl[8]),
    .scale_factor_on(ctl[7]), .symmetric_measure_on(ctl[6]), .reference_cycle_off(ctl[5]),
    .self_test_cycle_off(ctl[4]), .converter_calibration_off(ctl[3]),
    .watchdog_off(ctl[2]), .factory_scaling_on(ctl[1]), .user_correction_on(ctl[0]),
    .rated_weight_kg(weight_kg), .rated_sens_centi(sens_centi));

  // Free-running clock, 10 ns period
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Keep-alive pulses; stopping them lets the watchdog run out
  always @(posedge clock)
    process_data_seen <= feed & ~process_data_seen;

  task chk;
    input [31:0] got;
    input [31:0] exp;
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk1;
    input got;
    input exp;
    chk({{31{1'b0}}, got}, {{31{1'b0}}, exp});
  endtask

  task wr;
    input [5:0]  i;
    input [15:0] d;
    u_host.bus_write({i, 2'b00}, d);
  endtask

  task rd;
    input [5:0]  i;
    input [15:0] e;
    begin
      u_host.bus_read({i, 2'b00}, v);
      chk(v, {16'h0000, e});
    end
  endtask

  // Control outputs mirror the feature word minus bits 15, 14, 13 and 3
  task ctl_chk;
    input [15:0] f;
    chk({{20{1'b0}}, ctl}, {{20{1'b0}}, f[12:4], f[2:0]});
  endtask

  task meas;
    input [15:0] val;
    input        ok;
    input [15:0] e;
    begin
      @(posedge clock);
      meas_value <= val;
      meas_valid <= 1'b1;
      @(posedge clock);
      meas_valid <= 1'b0;
      #1;
      chk1(out_valid, ok);
      if (ok)
        chk({16'h0000, out_value}, {16'h0000, e});
    end
  endtask

  task recal;
    begin
      @(posedge clock);
      recal_done <= 1'b1;
      @(posedge clock);
      recal_done <= 1'b0;
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    $display("mismatch at %0t: timeout", $time);
    n_errors = n_errors + 1;
    end_sim;
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    feed = 1'b1;
    meas_value = 16'h0000;
    meas_valid = 1'b0;
    recal_done = 1'b0;
    weight_stable = 1'b1;
    process_data_seen = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(`LCF_IDX_FEATURE, 16'h0380);
    rd(`LCF_IDX_USER_OFFSET, 16'h0000);
    rd(`LCF_IDX_USER_GAIN, 16'h0800);
    rd(`LCF_IDX_RATED_WEIGHT, 16'h0005);
    rd(`LCF_IDX_RATED_SENS, 16'h0002);
    ctl_chk(16'h0380);
    chk({9'h000, sens_centi}, 32'h0000_00C8);
    wr(`LCF_IDX_IRQ_MASK, 16'h0002);
    wr(`LCF_IDX_FEATURE, 16'hFFFF);
    repeat (3) @(posedge clock);
    chk1(irq, 1'b1);
    rd(`LCF_IDX_IRQ_STATUS, 16'h0002);
    rd(`LCF_IDX_FEATURE, 16'h0380);
    chk1(irq, 1'b0);
    wr(`LCF_IDX_UNLOCK_KEY, `LCF_USER_KEY);
    wr(`LCF_IDX_PAGE_SELECT, 16'h0003);
    rd(`LCF_IDX_PAGE_SELECT, 16'h0000);
    wr(`LCF_IDX_PAGE_SELECT, 16'h0001);
    wr(`LCF_IDX_FEATURE, 16'h0000);
    rd(`LCF_IDX_FEATURE, 16'h0000);
    wr(`LCF_IDX_PAGE_SELECT, `LCF_PAGE_CONFIG);
    rd(`LCF_IDX_FEATURE, 16'h0380);
    wr(`LCF_IDX_FEATURE, 16'hFFFF);
    rd(`LCF_IDX_FEATURE, 16'h5FF7);
    ctl_chk(16'h5FF7);
    rd(6'h30, 16'h0000);
    u_host.bus_read({`LCF_IDX_FEATURE, 2'b01}, v);
    chk(v, 32'h0000_0000);
    wr(`LCF_IDX_FEATURE, 16'h0000);
    rd(`LCF_IDX_FEATURE, 16'h0000);
    ctl_chk(16'h0000);
    wr(`LCF_IDX_RATED_SENS, 16'h0007);
    wr(`LCF_IDX_RATED_WEIGHT, 16'h1234);
    rd(`LCF_IDX_RATED_SENS, 16'h0007);
    chk({9'h000, sens_centi}, 32'h0000_02BC);
    chk({16'h0000, weight_kg}, 32'h0000_1234);
    wr(`LCF_IDX_FEATURE, 16'h0800);
    rd(`LCF_IDX_FEATURE, 16'h0800);
    chk({9'h000, sens_centi}, 32'h0000_0007);
    meas(16'h0123, 1'b1, 16'h0123);
    wr(`LCF_IDX_USER_OFFSET, 16'h0010);
    wr(`LCF_IDX_USER_GAIN, 16'h0400);
    wr(`LCF_IDX_FEATURE, 16'h0001);
    meas(16'h0100, 1'b1, 16'h0090);
    wr(`LCF_IDX_FEATURE, 16'h0401);
    meas(16'h0100, 1'b1, 16'h0090);
    wr(`LCF_IDX_USER_GAIN, 16'h0800);
    meas(16'h0100, 1'b1, 16'h0110);
    wr(`LCF_IDX_FEATURE, 16'h0000);
    @(posedge clock);
    weight_stable <= 1'b0;
    recal;
    meas(16'h0066, 1'b1, 16'h0066);
    wr(`LCF_IDX_FEATURE, 16'h1000);
    recal;
    meas(16'h0055, 1'b0, 16'h0000);
    @(posedge clock);
    weight_stable <= 1'b1;
    meas(16'h0055, 1'b1, 16'h0055);
    rd(`LCF_IDX_IRQ_STATUS, 16'h0004);
    wr(`LCF_IDX_IRQ_MASK, 16'h0001);
    feed <= 1'b0;
    k = 0;
    while (watchdog_trip !== 1'b1 && k < 40)
    begin
      @(posedge clock);
      k = k + 1;
    end
    chk1(watchdog_trip, 1'b1);
    repeat (3) @(posedge clock);
    chk1(irq, 1'b1);
    wr(`LCF_IDX_FEATURE, 16'h0004);
    repeat (2) @(posedge clock);
    k = 0;
    repeat (60)
    begin
      @(posedge clock);
      if (watchdog_trip === 1'b1)
        k = k + 1;
    end
    chk(k, 0);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wr(`LCF_IDX_FEATURE, 16'h0000);
    rd(`LCF_IDX_FEATURE, 16'h0380);
    end_sim;
  end
endmodule // lcf_config_page_test
